// ==== src/bsd_decoder.sv ====
// boot strap decoder: latches straps at reset release and decodes boot choice
// Notes on behaviour
// - top four strap bits pick boot source
// - bits four and three give bus width
// - bits two and one pick card port
// - strap word fixed to 01X001XX pattern
// - word 01100110 boots third port, 4-bit
// - word 01000101 boots second port, 4-bit
// - stay in reset while reset pin low
`timescale 1ns/1ps
module bsd_decoder
	import bsd_pkg::*;
(
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// board pins
	input  wire logic       hw_reset_n_i,
	input  wire logic       strap_bit_six_i,
	input  wire logic       strap_bit_two_i,
	input  wire logic       strap_bit_one_i,
	// decoded boot selection
	output logic      [2:0] boot_source_o,
	output logic      [1:0] bus_width_o,
	output logic      [1:0] card_port_o,
	output logic      [7:0] strap_word_o,
	output logic            config_valid_o,
	output logic            onboard_flash_boot_o,
	output logic            carrier_card_boot_o,
	// reset toward the rest of the module
	output logic            core_reset_o
);

	bsd_main_s  main_reg;
	bsd_main_s  main_next;
	logic [3:0] pins_sync;
	logic       rst_n_s;
	logic [7:0] word_now;

	// boot source from the top nibble
	function automatic logic [2:0] decode_source(input logic [7:0] w);
		logic [3:0] nib;
		nib = w[BSD_POS_SRC_HI:BSD_POS_SRC_LO];
		if (nib[3]) begin
			return BSD_SRC_NAND;
		end else if (nib[2:1] == 2'h3) begin
			return BSD_SRC_MMC;
		end else if (nib[2:1] == 2'h2) begin
			return BSD_SRC_SD;
		end else if (nib == 4'h3) begin
			return BSD_SRC_NOR;
		end else if (nib == 4'h2) begin
			return BSD_SRC_SATA;
		end
		return BSD_SRC_NONE;
	endfunction

	// bus width; 8-bit only for the MMC source
	function automatic logic [1:0] decode_width(input logic [7:0] w);
		logic [2:0] src;
		logic [1:0] fld;
		src = decode_source(w);
		fld = w[BSD_POS_WID_HI:BSD_POS_WID_LO];
		if (src == BSD_SRC_MMC && fld == 2'h2) begin
			return BSD_WID_8;
		end else if ((src == BSD_SRC_MMC || src == BSD_SRC_SD) && fld[0]) begin
			return BSD_WID_4;
		end
		return BSD_WID_1;
	endfunction

	// card port; meaningless outside card boot, so reported as none
	function automatic logic [1:0] decode_port(input logic [7:0] w);
		logic [2:0] src;
		src = decode_source(w);
		if (src == BSD_SRC_MMC || src == BSD_SRC_SD) begin
			return w[BSD_POS_PORT_HI:BSD_POS_PORT_LO];
		end
		return BSD_PORT_NONE;
	endfunction

	// pins are from the board, so all pass two flops first
	bsd_sync #(
		.W       (4),
		.RST_VAL (BSD_RST_SYNC)
	) u_sync (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.async_i ({hw_reset_n_i, strap_bit_six_i, strap_bit_two_i, strap_bit_one_i}),
		.sync_o  (pins_sync)
	);

	assign rst_n_s = pins_sync[3];

	// only three bits come from the board, the rest are fixed on-module
	always_comb begin
		word_now                    = BSD_FIXED_VALUE;
		word_now[BSD_POS_STRAP_SIX] = pins_sync[2];
		word_now[BSD_POS_STRAP_TWO] = pins_sync[1];
		word_now[BSD_POS_STRAP_ONE] = pins_sync[0];
	end

	// sequence: hold in reset, take one sample, then run
	always_comb begin
		main_next = main_reg;
		case (main_reg.state)
			BSD_HOLD: begin
				if (rst_n_s) begin
					main_next.state = BSD_SAMPLE;
				end
			end
			BSD_SAMPLE: begin
				// straps taken exactly once per release
				main_next.word    = word_now;
				main_next.src     = decode_source(word_now);
				main_next.width   = decode_width(word_now);
				main_next.port    = decode_port(word_now);
				main_next.onboard = (word_now == BSD_WORD_ONBOARD);
				main_next.carrier = (word_now == BSD_WORD_CARRIER);
				main_next.valid   = 1'b1;
				main_next.state   = BSD_RUN;
			end
			BSD_RUN: begin
				main_next.state = BSD_RUN;
			end
			default: begin
				main_next.state = BSD_HOLD;
			end
		endcase
		// a low pin wins from any state; decoded values kept but marked stale
		if (!rst_n_s) begin
			main_next.state = BSD_HOLD;
			main_next.valid = 1'b0;
		end
		main_next.core_rst = (main_next.state != BSD_RUN);
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			main_reg          <= '0;
			main_reg.state    <= BSD_HOLD;
			main_reg.word     <= BSD_RST_WORD;
			main_reg.src      <= BSD_SRC_NONE;
			main_reg.width    <= BSD_WID_1;
			main_reg.port     <= BSD_PORT_NONE;
			main_reg.core_rst <= 1'b1;
		end else begin
			main_reg <= main_next;
		end
	end

	// outputs straight from the state register
	assign boot_source_o        = main_reg.src;
	assign bus_width_o          = main_reg.width;
	assign card_port_o          = main_reg.port;
	assign strap_word_o         = main_reg.word;
	assign config_valid_o       = main_reg.valid;
	assign onboard_flash_boot_o = main_reg.onboard;
	assign carrier_card_boot_o  = main_reg.carrier;
	assign core_reset_o         = main_reg.core_rst;

	// fields of the latched word, read apart from the decode functions
	logic [3:0] seen_nib;
	logic [1:0] seen_fld;

	assign seen_nib = strap_word_o[BSD_POS_SRC_HI:BSD_POS_SRC_LO];
	assign seen_fld = strap_word_o[BSD_POS_WID_HI:BSD_POS_WID_LO];

	// checks on the decoded selection and the reset sequence
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// written out field by field so a broken decode function is caught
	source_decode_a: assert property (
		config_valid_o |-> boot_source_o == (seen_nib[3] ? BSD_SRC_NAND
		: seen_nib[3:1] == 3'h3 ? BSD_SRC_MMC
		: seen_nib[3:1] == 3'h2 ? BSD_SRC_SD
		: seen_nib == 4'h3 ? BSD_SRC_NOR
		: seen_nib == 4'h2 ? BSD_SRC_SATA : BSD_SRC_NONE))
		else $error("boot source does not match strap word");

	width_decode_a: assert property (
		config_valid_o |-> bus_width_o == ((boot_source_o == BSD_SRC_MMC && seen_fld == 2'h2)
		? BSD_WID_8 : (seen_nib[3:2] == 2'h1 && seen_fld[0]) ? BSD_WID_4 : BSD_WID_1))
		else $error("bus width does not match strap word");

	sd_width_a: assert property (
		config_valid_o && boot_source_o == BSD_SRC_SD |-> bus_width_o != BSD_WID_8)
		else $error("sd boot reports 8-bit bus");

	port_decode_a: assert property (
		config_valid_o |-> card_port_o == ((seen_nib[3:2] == 2'h1)
		? strap_word_o[BSD_POS_PORT_HI:BSD_POS_PORT_LO] : BSD_PORT_NONE))
		else $error("card port does not match strap word");

	fixed_bits_a: assert property (
		config_valid_o |-> (strap_word_o & BSD_FIXED_MASK) == BSD_FIXED_VALUE)
		else $error("fixed strap bits wrong");

	onboard_case_a: assert property (
		config_valid_o && strap_word_o == BSD_WORD_ONBOARD |-> boot_source_o == BSD_SRC_MMC
		&& bus_width_o == BSD_WID_4 && card_port_o == BSD_PORT_THIRD && onboard_flash_boot_o)
		else $error("on-module flash case decoded wrong");

	carrier_case_a: assert property (
		config_valid_o && strap_word_o == BSD_WORD_CARRIER |-> boot_source_o == BSD_SRC_SD
		&& bus_width_o == BSD_WID_4 && card_port_o == BSD_PORT_SECOND && carrier_card_boot_o)
		else $error("carrier card case decoded wrong");

	reset_hold_a: assert property (
		!rst_n_s |=> core_reset_o && !config_valid_o)
		else $error("core left reset while pin low");

	release_time_a: assert property (
		!rst_n_s ##1 rst_n_s [*2] |=> !core_reset_o && config_valid_o)
		else $error("release sequence took wrong number of cycles");

	word_stable_a: assert property (
		config_valid_o && $past(config_valid_o) |-> $stable(strap_word_o) && $stable(boot_source_o))
		else $error("boot selection changed without reset");

	onboard_boot_c: cover property (config_valid_o && onboard_flash_boot_o);
	carrier_boot_c: cover property (config_valid_o && carrier_card_boot_o);
	rerun_reset_c:  cover property (config_valid_o ##1 !config_valid_o ##[1:20] config_valid_o);

endmodule

// ==== src/bsd_pkg.sv ====
// constants, codes and state types for the boot strap decoder
package bsd_pkg;

	// strap word layout: printed bit n sits at index n-1
	localparam int         BSD_STRAP_W       = 8;
	localparam int         BSD_POS_STRAP_SIX = 5;
	localparam int         BSD_POS_STRAP_TWO = 1;
	localparam int         BSD_POS_STRAP_ONE = 0;
	localparam int         BSD_POS_SRC_HI    = 7;
	localparam int         BSD_POS_SRC_LO    = 4;
	localparam int         BSD_POS_WID_HI    = 3;
	localparam int         BSD_POS_WID_LO    = 2;
	localparam int         BSD_POS_PORT_HI   = 1;
	localparam int         BSD_POS_PORT_LO   = 0;

	// fixed on-module pattern 01X001XX
	localparam logic [7:0] BSD_FIXED_MASK    = 8'hDC;
	localparam logic [7:0] BSD_FIXED_VALUE   = 8'h44;

	// named use cases
	localparam logic [7:0] BSD_WORD_ONBOARD  = 8'h66;
	localparam logic [7:0] BSD_WORD_CARRIER  = 8'h45;

	// boot source codes
	localparam logic [2:0] BSD_SRC_NONE      = 3'h0;
	localparam logic [2:0] BSD_SRC_NAND      = 3'h1;
	localparam logic [2:0] BSD_SRC_MMC       = 3'h2;
	localparam logic [2:0] BSD_SRC_SD        = 3'h3;
	localparam logic [2:0] BSD_SRC_NOR       = 3'h4;
	localparam logic [2:0] BSD_SRC_SATA      = 3'h5;

	// bus width codes
	localparam logic [1:0] BSD_WID_1         = 2'h0;
	localparam logic [1:0] BSD_WID_4         = 2'h1;
	localparam logic [1:0] BSD_WID_8         = 2'h2;

	// card port codes
	localparam logic [1:0] BSD_PORT_NONE     = 2'h0;
	localparam logic [1:0] BSD_PORT_SECOND   = 2'h1;
	localparam logic [1:0] BSD_PORT_THIRD    = 2'h2;
	localparam logic [1:0] BSD_PORT_FOURTH   = 2'h3;

	// reset values
	localparam logic [7:0] BSD_RST_WORD      = 8'h00;
	localparam logic [3:0] BSD_RST_SYNC      = 4'h0;

	typedef enum logic [1:0] {
		BSD_HOLD,
		BSD_SAMPLE,
		BSD_RUN
	} bsd_state_e;

	typedef struct packed {
		bsd_state_e state;
		logic [7:0] word;
		logic [2:0] src;
		logic [1:0] width;
		logic [1:0] port;
		logic       valid;
		logic       core_rst;
		logic       onboard;
		logic       carrier;
	} bsd_main_s;

endpackage

// ==== src/bsd_sync.sv ====
// two-flop synchroniser for board-driven levels
`timescale 1ns/1ps
module bsd_sync #(
	parameter int         W       = 4,
	parameter logic [3:0] RST_VAL = 4'h0
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// levels
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} bsd_sync_s;

	bsd_sync_s sync_reg;
	bsd_sync_s sync_next;

	// refuse widths the reset value cannot cover
	if (W < 1 || W > 4) begin : g_bad_width
		$error("bsd_sync width must be 1 to 4");
	end

	// first stage feeds only the second stage
	always_comb begin
		sync_next        = sync_reg;
		sync_next.meta   = async_i;
		sync_next.stable = sync_reg.meta;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sync_reg <= {RST_VAL[W-1:0], RST_VAL[W-1:0]};
		end else begin
			sync_reg <= sync_next;
		end
	end

	assign sync_o = sync_reg.stable;

endmodule

// ==== tb/bsd_carrier_model.sv ====
// carrier board model: strap drivers and reset driver
`timescale 1ns/1ps
module bsd_carrier_model (
	// clock
	input  wire logic       clk_i,
	// wanted levels
	input  wire logic       rst_n_want_i,
	input  wire logic [2:0] strap_want_i,
	// board pins
	output logic            hw_reset_n_o,
	output logic      [2:0] strap_o
);
	// the board moves its pins on rising edges only, as a real driver would
	always_ff @(posedge clk_i) begin
		hw_reset_n_o <= rst_n_want_i;
		strap_o      <= strap_want_i;
	end
endmodule

// ==== tb/bsd_decoder_tb_top.sv ====
// testbench for the boot strap decoder
`timescale 1ns/1ps
module bsd_decoder_tb_top;
	import bsd_pkg::*;
	logic       clk_i      = 1'b0;
	logic       rst_i      = 1'b1;
	logic       rst_n_want = 1'b0;
	logic [2:0] strap_want = 3'h0;
	logic       hw_n;
	logic [2:0] pins;
	logic [2:0] src;
	logic [1:0] wid;
	logic [1:0] port;
	logic [7:0] word;
	logic       valid;
	logic       onb;
	logic       car;
	logic       core;
	int         n_mismatch = 0;
	int         compares   = 0;

	// clock at 40 MHz
	initial begin
		forever #12.5 clk_i = ~clk_i;
	end

	bsd_carrier_model board (
		.clk_i        (clk_i),
		.rst_n_want_i (rst_n_want),
		.strap_want_i (strap_want),
		.hw_reset_n_o (hw_n),
		.strap_o      (pins)
	);

	bsd_decoder dut (
		.clk_i                (clk_i),
		.rst_i                (rst_i),
		.hw_reset_n_i         (hw_n),
		.strap_bit_six_i      (pins[2]),
		.strap_bit_two_i      (pins[1]),
		.strap_bit_one_i      (pins[0]),
		.boot_source_o        (src),
		.bus_width_o          (wid),
		.card_port_o          (port),
		.strap_word_o         (word),
		.config_valid_o       (valid),
		.onboard_flash_boot_o (onb),
		.carrier_card_boot_o  (car),
		.core_reset_o         (core)
	);

	// one compare, counted
	task automatic check(input logic [7:0] seen, input logic [7:0] want, input string what);
		compares++;
		if (seen !== want) begin
			n_mismatch++;
			$display("BAD %0t %s seen %h want %h", $time, what, seen, want);
		end
	endtask

	// verdict and end of run
	task automatic test_done();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// expected word: fixed bits around the three board bits
	function automatic logic [7:0] word_of(input logic [2:0] s);
		return {2'b01, s[2], 3'b001, s[1:0]};
	endfunction

	// reset pulse with new straps, then bounded wait for the decode
	task automatic boot(input logic [2:0] s);
		int i;
		@(posedge clk_i);
		rst_n_want <= 1'b0;
		strap_want <= s;
		repeat (6) @(negedge clk_i);
		check(8'(core), 8'h01, "core reset held");
		check(8'(valid), 8'h00, "valid in reset");
		@(posedge clk_i);
		rst_n_want <= 1'b1;
		for (i = 0; i < 20 && valid !== 1'b1; i++) begin
			@(negedge clk_i);
		end
		if (valid !== 1'b1) begin
			n_mismatch++;
			$display("BAD %0t decode never became valid", $time);
			test_done();
		end
	endtask

	initial begin
		int         k;
		logic [7:0] w;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		// every board setting, each followed by a strap change while running
		for (k = 0; k < 8; k++) begin
			boot(k[2:0]);
			w = word_of(k[2:0]);
			check(word, w, "strap word");
			check(8'(src), w[5] ? 8'(BSD_SRC_MMC) : 8'(BSD_SRC_SD), "source");
			check(8'(wid), 8'(BSD_WID_4), "width");
			check(8'(port), 8'(w[1:0]), "port");
			check(8'(onb), 8'(w == BSD_WORD_ONBOARD), "onboard");
			check(8'(car), 8'(w == BSD_WORD_CARRIER), "carrier");
			check(8'(core), 8'h00, "core released");
			// straps wiggling after release must not reach the decode
			@(posedge clk_i);
			strap_want <= ~k[2:0];
			repeat (6) @(negedge clk_i);
			check(word, w, "word held");
			check(8'(port), 8'(w[1:0]), "port held");
			check(8'(valid), 8'h01, "valid held");
			check(8'(src), w[5] ? 8'(BSD_SRC_MMC) : 8'(BSD_SRC_SD), "source held");
			check(8'(car), 8'(w == BSD_WORD_CARRIER), "carrier held");
			$display("test boot %0d done", k);
		end
		// system reset in mid-run clears the decode
		@(posedge clk_i);
		rst_i <= 1'b1;
		@(negedge clk_i);
		check(8'(core), 8'h01, "core in sys reset");
		check(word, BSD_RST_WORD, "word in sys reset");
		$display("test system reset done");
		// release with the pin already high, then a fresh pin-driven boot
		@(posedge clk_i);
		rst_i <= 1'b0;
		boot(3'h6);
		check(word, BSD_WORD_ONBOARD, "word after sys reset");
		check(8'(onb), 8'h01, "onboard after sys reset");
		check(8'(port), 8'(BSD_PORT_THIRD), "port after sys reset");
		$display("test release after system reset done");
		test_done();
	end
endmodule
